// ==== pifp2_pkg.sv ====
// Behaviour
// - Low-voltage event sets flag bit 2; it stays set until software clears it.
// - Hardware never clears the low-voltage flag; zero means supply above trip point.
// - Timer-c overflow sets flag bit 1; it stays set until software clears it.
// - Capture of timer-a or timer-c in capture mode sets flag bit 0; software clears.
// - Small package: comparator and capture/compare flag and priority bits read zero.
// - Bits 7 and 5 of flag and priority registers read zero; writes ignored.
// - Implemented priority bits are read/write, reset to one; one means high priority.
package pifp2_pkg;
    localparam int            PIFP2_AW          = 3;
    localparam logic [2:0]    PIFP2_ADDR_FLAGS  = 3'h0;
    localparam logic [2:0]    PIFP2_ADDR_PRIO   = 3'h1;
    localparam logic [2:0]    PIFP2_ADDR_ISTAT  = 3'h2;
    localparam logic [2:0]    PIFP2_ADDR_IMASK  = 3'h3;
    localparam logic [2:0]    PIFP2_ADDR_CTRL   = 3'h4;

    localparam int            PIFP2_BIT_CAPCMP  = 0;
    localparam int            PIFP2_BIT_TIMERC  = 1;
    localparam int            PIFP2_BIT_LOWV    = 2;
    localparam int            PIFP2_BIT_BUSCOL  = 3;
    localparam int            PIFP2_BIT_NVM     = 4;
    localparam int            PIFP2_BIT_CMP     = 6;

    // Implemented positions: bits 7 and 5 never exist
    localparam logic [7:0]    PIFP2_IMPL_FULL   = 8'h5f;
    // Smaller package drops comparator and capture/compare bits
    localparam logic [7:0]    PIFP2_IMPL_SMALL  = 8'h1e;
    localparam logic [7:0]    PIFP2_FLAGS_RST   = 8'h00;
    localparam logic [7:0]    PIFP2_PRIO_RST    = 8'h5f;
    localparam logic [7:0]    PIFP2_ZERO        = 8'h00;

    typedef struct packed {
        logic [PIFP2_AW-1:0] addr;
        logic [7:0]          wdata;
        logic                wr;
        logic                rd;
    } pifp2_bus_s;

    typedef struct packed {
        logic cmp;
        logic nvm;
        logic busCol;
        logic lowVolt;
        logic timerCOvf;
        logic capture;
    } pifp2_evt_s;
endpackage

// ==== pifp2_sticky_bit.sv ====
`timescale 1ns/100ps
module pifp2_sticky_bit
    import pifp2_pkg::*;
(
    input  wire logic mclk,
    input  wire logic srst,
    input  wire logic impl,
    input  wire logic setEvt,
    input  wire logic clrReq,
    output logic      flag_reg
);
    // Set has priority over clear so an event is never dropped
    always_ff @(posedge mclk)
    begin
        if (srst || !impl)
            flag_reg <= 1'h0;
        else if (setEvt)
            flag_reg <= 1'h1;
        else if (clrReq)
            flag_reg <= 1'h0;
    end
endmodule

// ==== pifp2_periph_irq.sv ====
`timescale 1ns/100ps
module pifp2_periph_irq
    import pifp2_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       srst,
    input  wire logic       smallPkg,
    input  pifp2_bus_s      bus,
    input  pifp2_evt_s      evt,
    output logic [7:0]      rdata_reg,
    output logic [7:0]      flags_reg,
    output logic [7:0]      prio_reg,
    output logic            irq_reg
);
    logic [7:0] impl;
    logic [7:0] evtVec;
    logic [7:0] flagWrClr;
    logic [7:0] flagWrSet;
    logic [7:0] flagsNow;
    logic [7:0] istat_reg;
    logic [7:0] imask_reg;
    logic       small_reg;
    logic       wrFlags;
    logic       wrIstat;

    assign impl = small_reg ? PIFP2_IMPL_SMALL : PIFP2_IMPL_FULL;

    assign evtVec = {1'h0, evt.cmp, 1'h0, evt.nvm, evt.busCol,
                     evt.lowVolt, evt.timerCOvf, evt.capture};

    assign wrFlags = bus.wr && (bus.addr == PIFP2_ADDR_FLAGS);
    assign wrIstat = bus.wr && (bus.addr == PIFP2_ADDR_ISTAT);

    // Software may write a flag to one or zero; hardware only ever sets
    assign flagWrClr = wrFlags ? ~bus.wdata : PIFP2_ZERO;
    assign flagWrSet = wrFlags ? bus.wdata : PIFP2_ZERO;

    // Package strap sampled by a clocked process
    always_ff @(posedge mclk)
    begin
        if (srst)
            small_reg <= smallPkg;
    end

    genvar i;
    generate
        for (i = 0; i < 8; i++)
        begin : g_flag
            pifp2_sticky_bit u_bit (
                .mclk     (mclk),
                .srst     (srst),
                .impl     (impl[i]),
                .setEvt   (evtVec[i] | flagWrSet[i]),
                .clrReq   (flagWrClr[i]),
                .flag_reg (flagsNow[i])
            );
        end
    endgenerate

    assign flags_reg = flagsNow;

    always_ff @(posedge mclk)
    begin
        // Strap applied at reset so absent bits never read as one after release
        if (srst)
            prio_reg <= PIFP2_PRIO_RST
                        & (smallPkg ? PIFP2_IMPL_SMALL : PIFP2_IMPL_FULL);
        else if (bus.wr && (bus.addr == PIFP2_ADDR_PRIO))
            prio_reg <= bus.wdata & impl;
        else
            prio_reg <= prio_reg & impl;
    end

    // Interrupt status latches new events; write one to clear, set wins
    always_ff @(posedge mclk)
    begin
        if (srst)
            istat_reg <= PIFP2_ZERO;
        else
            istat_reg <= ((istat_reg & ~(wrIstat ? bus.wdata : PIFP2_ZERO))
                          | (evtVec & impl));
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            imask_reg <= PIFP2_ZERO;
        else if (bus.wr && (bus.addr == PIFP2_ADDR_IMASK))
            imask_reg <= bus.wdata & impl;
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            irq_reg <= 1'h0;
        else
            irq_reg <= |(istat_reg & imask_reg);
    end

    // Read data valid the cycle after the strobe only; unmapped reads zero
    always_ff @(posedge mclk)
    begin
        if (srst || !bus.rd)
            rdata_reg <= PIFP2_ZERO;
        else
        begin
            unique case (bus.addr)
                PIFP2_ADDR_FLAGS: rdata_reg <= flagsNow & impl;
                PIFP2_ADDR_PRIO:  rdata_reg <= prio_reg & impl;
                PIFP2_ADDR_ISTAT: rdata_reg <= istat_reg;
                PIFP2_ADDR_IMASK: rdata_reg <= imask_reg;
                PIFP2_ADDR_CTRL:  rdata_reg <= {7'h00, small_reg};
                default:          rdata_reg <= PIFP2_ZERO;
            endcase
        end
    end
endmodule

// ==== pifp2_periph_irq_properties.sv ====
`timescale 1ns/100ps
module pifp2_periph_irq_props
    import pifp2_pkg::*;
(
    input wire logic       mclk,
    input wire logic       srst,
    input wire logic       smallPkg,
    input pifp2_bus_s      bus,
    input pifp2_evt_s      evt,
    input wire logic [7:0] rdata_reg,
    input wire logic [7:0] flags_reg,
    input wire logic [7:0] prio_reg,
    input wire logic       irq_reg
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    wire logic [7:0] impl = smallPkg ? PIFP2_IMPL_SMALL : PIFP2_IMPL_FULL;
    wire logic       lowClr = bus.wr && bus.addr == PIFP2_ADDR_FLAGS && !bus.wdata[2];
    wire logic       prioWr = bus.wr && bus.addr == PIFP2_ADDR_PRIO;
    sequence prioWrite;
        prioWr;
    endsequence
    lowv_set_a: assert property (evt.lowVolt |=> flags_reg[2])
        else $error("Low-voltage flag missed");
    lowv_keep_a: assert property (flags_reg[2] && !lowClr |=> flags_reg[2])
        else $error("Low-voltage flag dropped");
    timerc_set_a: assert property (evt.timerCOvf |=> flags_reg[1])
        else $error("Overflow flag missed");
    capture_set_a: assert property (evt.capture && !smallPkg |=> flags_reg[0])
        else $error("Capture flag missed");
    small_zero_a: assert property (smallPkg |-> ((flags_reg | prio_reg) & 8'h41) == 8'h00)
        else $error("Absent bit set");
    unimpl_zero_a: assert property (((flags_reg | prio_reg) & 8'ha0) == 8'h00)
        else $error("Unimplemented bit set");
    prio_write_a: assert property (prioWrite |=> prio_reg == ($past(bus.wdata) & impl))
        else $error("Priority write wrong");
    prio_hold_a: assert property (!prioWr |=> $stable(prio_reg))
        else $error("Priority changed");
endmodule

// ==== tb.sv ====
`timescale 1ns/100ps
module tb import pifp2_pkg::*;;
    logic       mclk = 1'h0;
    logic       srst = 1'h1;
    logic       smallPkg = 1'h0;
    pifp2_bus_s bus = '0;
    pifp2_evt_s evt = '0;
    logic [7:0] rdata, flags, prio;
    logic       irq;
    int         failCount = 0;
    int         samplesChecked = 0;
    pifp2_periph_irq dut_u (.mclk(mclk), .srst(srst), .smallPkg(smallPkg), .bus(bus),
        .evt(evt), .rdata_reg(rdata), .flags_reg(flags), .prio_reg(prio), .irq_reg(irq));
    initial forever #12.5 mclk = ~mclk;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samplesChecked++;
        if (seen !== exp)
        begin
            failCount++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic completeRun();
        $display("Compares %0d, mismatches %0d", samplesChecked, failCount);
        if (failCount == 0 && samplesChecked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        int         rg[8];
        int         e, im, rM, iM, a;
        logic       r, wasRst;
        logic [2:0] ad;
        void'($urandom(81));
        for (int i = 0; i < 800; i++)
        begin
            @(posedge mclk);
            wasRst = srst;
            im = smallPkg ? PIFP2_IMPL_SMALL : PIFP2_IMPL_FULL;
            rM = bus.rd ? rg[bus.addr] : 0;
            iM = (rg[2] & rg[3]) != 0;
            if (bus.wr && bus.addr < 4)
                rg[bus.addr] = bus.addr == 2 ? rg[2] & ~bus.wdata : bus.wdata;
            e = {evt.cmp, 1'h0, evt[4:0]};
            // Event ORed in after the write, so a clear never loses it
            for (int k = 0; k < 4; k++)
                rg[k] = k[0] ? rg[k] & im : (rg[k] | e) & im;
            if (srst)
                rg = '{PIFP2_FLAGS_RST, PIFP2_PRIO_RST & im, 0, 0, smallPkg, 0, 0, 0};
            r = i < 5 || (i >= 400 && i < 406);
            a = $urandom % 3;
            ad = 3'($urandom);
            srst <= r;
            smallPkg <= i >= 400;
            bus.addr <= ad;
            bus.wdata <= ad == 3'h3 ? 8'($urandom) & 8'(im) : 8'($urandom);
            bus.wr <= !r && a == 1;
            bus.rd <= !r && a == 2;
            evt <= (r || $urandom % 4 != 0) ? 6'h00 : 6'($urandom);
            @(negedge mclk);
            if (!wasRst)
            begin
                check(rdata, 8'(rM));
                check(flags, 8'(rg[0]));
                check(prio, 8'(rg[1]));
                check({7'h00, irq}, 8'(iM));
            end
        end
        completeRun();
    end
endmodule
bind pifp2_periph_irq pifp2_periph_irq_props chk_u (.mclk(mclk), .srst(srst),
    .smallPkg(smallPkg), .bus(bus), .evt(evt), .rdata_reg(rdata_reg),
    .flags_reg(flags_reg), .prio_reg(prio_reg), .irq_reg(irq_reg));
